// [hw/pllsr_top.sv]
// PLL control and status readback register bank with its register access port
`timescale 1ns/1ps
`include "pllsr_params.svh"
module pllsr_top
  import pllsr_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic [9:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  input  wire logic       vco_cal_done_in,
  input  wire logic       holdover_active_in,
  input  wire logic       second_ref_selected_in,
  input  wire logic       ref_diff_mode_in,
  input  wire logic       vco_above_thresh_in,
  input  wire logic       first_ref_above_lo_in,
  input  wire logic       first_ref_above_hi_in,
  input  wire logic       second_ref_above_lo_in,
  input  wire logic       second_ref_above_hi_in,
  input  wire logic       digital_lock_in,
  output logic            zero_delay_en_out,
  output logic            ext_zero_delay_en_out,
  output logic      [1:0] zd_feedback_div_sel_out,
  output logic            ref_thresh_sel_out
);
  pllsr_byte_t  zd_ctrl_q;
  pllsr_byte_t  zd_ctrl_d;
  pllsr_byte_t  refmon_q;
  pllsr_byte_t  refmon_d;
  pllsr_byte_t  rdata_q;
  pllsr_byte_t  rdata_d;
  pllsr_state_e state_q;
  pllsr_state_e state_d;
  pllsr_byte_t  status_live;
  pllsr_byte_t  status_byte;
  pllsr_byte_t  rd_mux;
  logic         hit_refmon;
  logic         hit_zd;
  logic         hit_status;
  logic         wr_refmon;
  logic         wr_zd;

  // Address decode
  assign hit_refmon = (reg_addr_in == `PLLSR_ADDR_REFMON);
  assign hit_zd     = (reg_addr_in == `PLLSR_ADDR_ZD_CTRL);
  assign hit_status = (reg_addr_in == `PLLSR_ADDR_STATUS);
  assign wr_refmon  = reg_wr_in & hit_refmon;
  assign wr_zd      = reg_wr_in & hit_zd;

  // Writes to the status address decode to nothing, so they fall away
  assign refmon_d = wr_refmon ? reg_wdata_in : refmon_q;
  assign zd_ctrl_d = wr_zd ? (reg_wdata_in & `PLLSR_ZD_MASK) : zd_ctrl_q;

  pllsr_status u_status (
    .thresh_sel_in          (refmon_q[`PLLSR_REFMON_THR_BIT]),
    .vco_cal_done_in        (vco_cal_done_in),
    .holdover_active_in     (holdover_active_in),
    .second_ref_selected_in (second_ref_selected_in),
    .ref_diff_mode_in       (ref_diff_mode_in),
    .vco_above_thresh_in    (vco_above_thresh_in),
    .ref_above_lo_in        ({second_ref_above_lo_in, first_ref_above_lo_in}),
    .ref_above_hi_in        ({second_ref_above_hi_in, first_ref_above_hi_in}),
    .status_out             (status_live)
  );

  // Lock result joins here so the submodule stays a pure monitor selector
  assign status_byte = status_live | {7'h00, digital_lock_in};

  // Status is sampled on the read edge itself; no stale copy is held
  assign rd_mux = hit_status ? status_byte :
                  hit_zd     ? zd_ctrl_q   :
                  hit_refmon ? refmon_q    : `PLLSR_UNMAPPED_DATA;
  assign rdata_d = reg_rd_in ? rd_mux : rdata_q;

  always_comb begin
    case (state_q)
      PLLSR_IDLE: state_d = reg_rd_in ? PLLSR_RESP : PLLSR_IDLE;
      PLLSR_RESP: state_d = reg_rd_in ? PLLSR_RESP : PLLSR_IDLE;
      default:    state_d = PLLSR_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      zd_ctrl_q <= `PLLSR_ZD_RST;
      refmon_q  <= `PLLSR_REFMON_RST;
      rdata_q   <= 8'h00;
      state_q   <= PLLSR_IDLE;
    end else begin
      zd_ctrl_q <= zd_ctrl_d;
      refmon_q  <= refmon_d;
      rdata_q   <= rdata_d;
      state_q   <= state_d;
    end
  end

  assign reg_rdata_out           = rdata_q;
  assign reg_rvalid_out          = (state_q == PLLSR_RESP);
  assign zero_delay_en_out       = zd_ctrl_q[`PLLSR_ZD_EN_BIT];
  // External mode only matters while zero delay itself is on
  assign ext_zero_delay_en_out   = zd_ctrl_q[`PLLSR_ZD_EN_BIT] & zd_ctrl_q[`PLLSR_ZD_EXT_BIT];
  assign zd_feedback_div_sel_out = zd_ctrl_q[`PLLSR_ZD_DIVSEL_HI:`PLLSR_ZD_DIVSEL_LO];
  assign ref_thresh_sel_out      = refmon_q[`PLLSR_REFMON_THR_BIT];

  // ---------------------------------------------------------------------------
  // Assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  logic rd_status;
  assign rd_status = reg_rd_in & hit_status;

  // Independent model of the status byte, placed bit by bit from the field positions
  logic        exp_first_reference_input_thr;
  logic        exp_second_reference_input_thr;
  pllsr_byte_t exp_status_byte;
  assign exp_first_reference_input_thr = ref_thresh_sel_out ? first_ref_above_hi_in : first_ref_above_lo_in;
  assign exp_second_reference_input_thr = ref_thresh_sel_out ? second_ref_above_hi_in : second_ref_above_lo_in;

  always_comb begin
    exp_status_byte                        = 8'h00;
    exp_status_byte[`PLLSR_ST_CAL_BIT]     = vco_cal_done_in;
    exp_status_byte[`PLLSR_ST_HOLD_BIT]    = holdover_active_in;
    exp_status_byte[`PLLSR_ST_REF2SEL_BIT] = second_ref_selected_in & ~ref_diff_mode_in;
    exp_status_byte[`PLLSR_ST_VCOTHR_BIT]  = vco_above_thresh_in;
    exp_status_byte[`PLLSR_ST_REF2THR_BIT] = exp_second_reference_input_thr;
    exp_status_byte[`PLLSR_ST_REF1THR_BIT] = exp_first_reference_input_thr;
    exp_status_byte[`PLLSR_ST_LOCK_BIT]    = digital_lock_in;
  end

  zd_enable_write_a: assert property (
    wr_zd |=> zero_delay_en_out == $past(reg_wdata_in[`PLLSR_ZD_EN_BIT]))
    else $error("zero delay enable does not follow the written bit");

  zd_enable_hold_a: assert property (
    !wr_zd |=> $stable(zero_delay_en_out))
    else $error("zero delay enable changed without a write");

  zd_reset_off_a: assert property (
    $rose(rst_n_in) |-> !zero_delay_en_out && !ext_zero_delay_en_out)
    else $error("zero delay is on straight after reset");

  cal_done_bit_a: assert property (
    rd_status |=> reg_rvalid_out && reg_rdata_out[`PLLSR_ST_CAL_BIT] == $past(vco_cal_done_in))
    else $error("calibration bit wrong in status read");

  holdover_bit_a: assert property (
    rd_status |=> reg_rdata_out[`PLLSR_ST_HOLD_BIT] == $past(holdover_active_in))
    else $error("holdover bit wrong in status read");

  second_reference_input_select_a: assert property (
    rd_status |=> reg_rdata_out[`PLLSR_ST_REF2SEL_BIT] ==
                  $past(second_ref_selected_in && !ref_diff_mode_in))
    else $error("second reference select bit wrong");

  vco_thresh_a: assert property (
    rd_status |=> reg_rdata_out[`PLLSR_ST_VCOTHR_BIT] == $past(vco_above_thresh_in))
    else $error("VCO threshold bit wrong in status read");

  second_reference_input_freq_a: assert property (
    rd_status && ref_thresh_sel_out |=> reg_rdata_out[`PLLSR_ST_REF2THR_BIT] == $past(second_ref_above_hi_in))
    else $error("second reference frequency bit wrong on high threshold");

  first_reference_input_freq_a: assert property (
    rd_status && !ref_thresh_sel_out |=> reg_rdata_out[`PLLSR_ST_REF1THR_BIT] == $past(first_ref_above_lo_in))
    else $error("first reference frequency bit wrong on low threshold");

  thresh_select_a: assert property (
    wr_refmon ##1 rd_status |=>
      reg_rdata_out[`PLLSR_ST_REF1THR_BIT] ==
      ($past(reg_wdata_in[`PLLSR_REFMON_THR_BIT], 2) ? $past(first_ref_above_hi_in) : $past(first_ref_above_lo_in)))
    else $error("threshold select does not steer the reference bits");

  lock_bit_a: assert property (
    rd_status |=> reg_rdata_out[`PLLSR_ST_LOCK_BIT] == $past(digital_lock_in) && !reg_rdata_out[7])
    else $error("lock bit wrong in status read");

  status_ro_a: assert property (
    reg_wr_in && hit_status |=> $stable(zd_ctrl_q) && $stable(refmon_q))
    else $error("write to status register changed a control register");

  read_latency_a: assert property (
    !reg_rd_in |=> !reg_rvalid_out)
    else $error("read answer without a read request");

  second_reference_input_freq_lo_a: assert property (
    rd_status && !ref_thresh_sel_out |=>
      reg_rdata_out[`PLLSR_ST_REF2THR_BIT] == $past(second_ref_above_lo_in))
    else $error("second reference frequency bit wrong on low threshold");

  first_reference_input_freq_hi_a: assert property (
    rd_status && ref_thresh_sel_out |=>
      reg_rdata_out[`PLLSR_ST_REF1THR_BIT] == $past(first_ref_above_hi_in))
    else $error("first reference frequency bit wrong on high threshold");

  diff_hides_second_reference_input_a: assert property (
    rd_status && ref_diff_mode_in |=>
      !reg_rdata_out[`PLLSR_ST_REF2SEL_BIT])
    else $error("second reference reported in differential mode");

  cal_pending_a: assert property (
    rd_status && !vco_cal_done_in |=>
      !reg_rdata_out[`PLLSR_ST_CAL_BIT])
    else $error("calibration reported finished while still running");

  hold_idle_a: assert property (
    rd_status && !holdover_active_in |=>
      !reg_rdata_out[`PLLSR_ST_HOLD_BIT])
    else $error("holdover reported while not in holdover");

  vco_below_a: assert property (
    rd_status && !vco_above_thresh_in |=>
      !reg_rdata_out[`PLLSR_ST_VCOTHR_BIT])
    else $error("VCO reported above threshold while below");

  lock_lost_a: assert property (
    rd_status && !digital_lock_in |=>
      !reg_rdata_out[`PLLSR_ST_LOCK_BIT])
    else $error("lock reported while unlocked");

  status_model_a: assert property (
    rd_status |=>
      reg_rdata_out == $past(exp_status_byte))
    else $error("status read differs from the live conditions at the read edge");

  second_reference_input_steer_a: assert property (
    wr_refmon ##1 rd_status |=> reg_rdata_out[`PLLSR_ST_REF2THR_BIT] ==
      ($past(reg_wdata_in[`PLLSR_REFMON_THR_BIT], 2) ? $past(second_ref_above_hi_in) : $past(second_ref_above_lo_in)))
    else $error("threshold select does not steer the second reference bit");

  refmon_write_a: assert property (
    wr_refmon |=>
      ref_thresh_sel_out == $past(reg_wdata_in[`PLLSR_REFMON_THR_BIT]))
    else $error("threshold select does not follow the written bit");

  refmon_hold_a: assert property (
    !wr_refmon |=>
      $stable(refmon_q))
    else $error("threshold register changed without a write");

  refmon_readback_a: assert property (
    reg_rd_in && hit_refmon |=>
      reg_rdata_out == $past(refmon_q))
    else $error("threshold register read back wrong");

  zd_reserved_zero_a: assert property (
    (zd_ctrl_q & ~`PLLSR_ZD_MASK) ==
      8'h00)
    else $error("reserved zero delay bits hold a one");

  ext_zd_gate_a: assert property (
    ext_zero_delay_en_out |->
      zero_delay_en_out)
    else $error("external zero delay on while zero delay is off");

  ext_zd_write_a: assert property (
    wr_zd |=> ext_zero_delay_en_out ==
      $past(reg_wdata_in[`PLLSR_ZD_EN_BIT] && reg_wdata_in[`PLLSR_ZD_EXT_BIT]))
    else $error("external zero delay does not follow the written bits");

  div_sel_write_a: assert property (
    wr_zd |=> zd_feedback_div_sel_out ==
      $past(reg_wdata_in[`PLLSR_ZD_DIVSEL_HI:`PLLSR_ZD_DIVSEL_LO]))
    else $error("feedback divider select does not follow the written bits");

  zd_readback_a: assert property (
    reg_rd_in && hit_zd |=>
      reg_rdata_out == $past(zd_ctrl_q))
    else $error("zero delay register read back wrong");

  reset_quiet_a: assert property (
    $rose(rst_n_in) |-> !reg_rvalid_out && reg_rdata_out == 8'h00 &&
      !ref_thresh_sel_out && zd_feedback_div_sel_out == 2'h0)
    else $error("outputs not quiet straight after reset");

  unmapped_read_a: assert property (
    reg_rd_in && !hit_status && !hit_zd && !hit_refmon |=>
      reg_rdata_out == `PLLSR_UNMAPPED_DATA)
    else $error("unmapped read returned data");

  rdata_hold_a: assert property (
    !reg_rd_in |=>
      $stable(reg_rdata_out))
    else $error("read data changed without a read");

  read_answer_a: assert property (
    reg_rd_in |=>
      reg_rvalid_out)
    else $error("read request not answered in the next cycle");

  state_legal_a: assert property (
    state_q == PLLSR_IDLE ||
      state_q == PLLSR_RESP)
    else $error("read state machine in an unused state");

  status_read_c: cover property (rd_status ##1 reg_rvalid_out);
  rw_same_c:     cover property (reg_rd_in && wr_zd);
  zd_on_c:       cover property (wr_zd ##1 zero_delay_en_out ##1 ext_zero_delay_en_out);
  thresh_hi_c:   cover property (wr_refmon ##1 ref_thresh_sel_out ##1 rd_status);
  b2b_read_c:    cover property (reg_rd_in [*3]);
endmodule

// [hw/pllsr_params.svh]
// Register offsets, field positions and reset values of the PLL status readback block
`ifndef PLLSR_PARAMS_SVH
`define PLLSR_PARAMS_SVH

`define PLLSR_ADDR_W          10
`define PLLSR_ADDR_REFMON     10'h01A
`define PLLSR_ADDR_ZD_CTRL    10'h01E
`define PLLSR_ADDR_STATUS     10'h01F

`define PLLSR_REFMON_THR_BIT  6
`define PLLSR_REFMON_RST      8'h00

`define PLLSR_ZD_DIVSEL_HI    4
`define PLLSR_ZD_DIVSEL_LO    3
`define PLLSR_ZD_EXT_BIT      2
`define PLLSR_ZD_EN_BIT       1
`define PLLSR_ZD_MASK         8'h1E
`define PLLSR_ZD_RST          8'h00

`define PLLSR_ST_CAL_BIT      6
`define PLLSR_ST_HOLD_BIT     5
`define PLLSR_ST_REF2SEL_BIT  4
`define PLLSR_ST_VCOTHR_BIT   3
`define PLLSR_ST_REF2THR_BIT  2
`define PLLSR_ST_REF1THR_BIT  1
`define PLLSR_ST_LOCK_BIT     0

`define PLLSR_UNMAPPED_DATA   8'h00
`define PLLSR_RD_LATENCY      1

`endif

// [hw/pllsr_pkg.sv]
// Types shared by the PLL status readback block
package pllsr_pkg;
  typedef logic [9:0] pllsr_addr_t;
  typedef logic [7:0] pllsr_byte_t;
  typedef enum logic [1:0] {
    PLLSR_IDLE = 2'h0,
    PLLSR_RESP = 2'h1
  } pllsr_state_e;
endpackage

// [hw/pllsr_status.sv]
// Assembles the read-only status byte, all but the lock bit, from the live PLL conditions
`timescale 1ns/1ps
`include "pllsr_params.svh"
module pllsr_status
  import pllsr_pkg::*;
(
  input  wire logic       thresh_sel_in,
  input  wire logic       vco_cal_done_in,
  input  wire logic       holdover_active_in,
  input  wire logic       second_ref_selected_in,
  input  wire logic       ref_diff_mode_in,
  input  wire logic       vco_above_thresh_in,
  input  wire logic [1:0] ref_above_lo_in,
  input  wire logic [1:0] ref_above_hi_in,
  output pllsr_byte_t     status_out
);
  logic [1:0] ref_above;
  logic       second_reference_input_drives;

  // Index 0 is the first reference input, index 1 the second
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ref
      assign ref_above[g] = thresh_sel_in ? ref_above_hi_in[g] : ref_above_lo_in[g];
    end
  endgenerate

  // Differential mode uses the first input path, so it never reports the second reference
  assign second_reference_input_drives = second_ref_selected_in & ~ref_diff_mode_in;

  assign status_out = {1'b0,
                       vco_cal_done_in,
                       holdover_active_in,
                       second_reference_input_drives,
                       vco_above_thresh_in,
                       ref_above[1],
                       ref_above[0],
                       1'b0};
endmodule

// [tb/test_pll_status_readback.sv]
// Self-checking bench for the PLL control and status readback register bank
`timescale 1ns/1ps
module test_pll_status_readback;
  import pllsr_pkg::*;
  logic       mclk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic       cal = 1'b0, hold = 1'b0, r2sel = 1'b0, diff = 1'b0, vco = 1'b0, lock = 1'b0;
  logic       r1lo = 1'b0, r1hi = 1'b0, r2lo = 1'b0, r2hi = 1'b0;
  logic [7:0] rdata;
  logic       rvalid, zd_en, ext_zd, thr_sel;
  logic [1:0] div_sel;
  logic [7:0] rnd;
  int         err_count = 0;
  int         checked = 0;

  always #4 mclk_in = ~mclk_in;

  pllsr_top dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .vco_cal_done_in(cal), .holdover_active_in(hold), .second_ref_selected_in(r2sel),
    .ref_diff_mode_in(diff), .vco_above_thresh_in(vco), .first_ref_above_lo_in(r1lo),
    .first_ref_above_hi_in(r1hi), .second_ref_above_lo_in(r2lo), .second_ref_above_hi_in(r2hi),
    .digital_lock_in(lock), .zero_delay_en_out(zd_en), .ext_zero_delay_en_out(ext_zd),
    .zd_feedback_div_sel_out(div_sel), .ref_thresh_sel_out(thr_sel));

  // Differential mode hides the second-reference selection
  function automatic logic [7:0] exp_status(input logic sel);
    return {1'b0, cal, hold, r2sel & ~diff, vco, sel ? r2hi : r2lo, sel ? r1hi : r1lo, lock};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk_in);
    wr = 1'b0;
  endtask

  // Data and valid are looked at in the single cycle after the strobe
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp);
    @(negedge mclk_in);
    rd = 1'b1;
    addr = a;
    @(negedge mclk_in);
    rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask

  task automatic give_verdict();
    $display("Counts: checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    rnd = 8'($urandom(32'h3C59D8D1));
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_n_in = 1'b1;
    check({zd_en, ext_zd, div_sel, thr_sel, rvalid, 2'h0}, 8'h00);
    rd_reg(10'h01E, 8'h00);
    rd_reg(10'h01A, 8'h00);
    $display("test reset done");
    wr_reg(10'h01E, 8'h16);
    check({4'h0, zd_en, ext_zd, div_sel}, 8'h0E);
    rd_reg(10'h01E, 8'h16);
    wr_reg(10'h01E, 8'hFF);
    rd_reg(10'h01E, 8'h1E);
    wr_reg(10'h01E, 8'h00);
    check({7'h00, zd_en}, 8'h00);
    // Read and write in one cycle: the read sees the old contents
    @(negedge mclk_in);
    {rd, wr, addr, wdata} = {2'b11, 10'h01E, 8'h02};
    @(negedge mclk_in);
    {rd, wr} = 2'b00;
    check(rdata, 8'h00);
    check({7'h00, zd_en}, 8'h01);
    // External mode and divider select without the enable: external mode must stay off
    wr_reg(10'h01E, 8'h1C);
    check({4'h0, zd_en, ext_zd, div_sel}, 8'h03);
    $display("test zero delay done");
    {cal, hold, r2sel, diff, vco, r1lo, r2lo, lock} = 8'hFF;
    wr_reg(10'h01F, 8'hFF);
    rd_reg(10'h01F, exp_status(1'b0));
    rd_reg(10'h01E, 8'h1C);
    rd_reg(10'h01A, 8'h00);
    rd_reg(10'h155, 8'h00);
    $display("test read only done");
    // Read straight after the threshold write, then two more reads back to back
    wr_reg(10'h01A, 8'h40);
    {rd, addr} = {1'b1, 10'h01F};
    @(negedge mclk_in);
    check(rdata, exp_status(1'b1));
    addr = 10'h01A;
    @(negedge mclk_in);
    check(rdata, 8'h40);
    addr = 10'h01E;
    @(negedge mclk_in);
    {rd, addr} = {1'b0, 10'h000};
    check({7'h00, rvalid}, 8'h01);
    check(rdata, 8'h1C);
    $display("test back to back done");
    for (int i = 0; i < 60; i++) begin
      rnd = 8'($urandom);
      wr_reg(10'h01A, rnd);
      check({7'h00, thr_sel}, {7'h00, rnd[6]});
      {cal, hold, r2sel, diff, vco, lock, r1lo, r1hi} = 8'($urandom);
      {r2lo, r2hi} = 2'($urandom);
      if (i < 4) begin
        diff = 1'b0;
        {cal, hold, r2sel, vco, lock} = {5{i[0]}};
      end
      rd_reg(10'h01F, exp_status(rnd[6]));
    end
    $display("test random status done");
    give_verdict();
  end
endmodule
